// ### include/mfem_pkg.sv
package mfem_pkg;

	// Multiframe geometry
	localparam int          MF_PERIOD_MS = 5;
	localparam int          MF_FRAMES    = 20;
	localparam int          FRAME_IDX_W  = 5;
	localparam logic [4:0]  FRAME_FIRST  = 5'h00;
	localparam logic [4:0]  FRAME_LAST   = 5'h13;
	localparam logic [4:0]  FRAME_STEP   = 5'h01;

	// SC1 message codes
	localparam logic [3:0]  SC1_FECV     = 4'he;
	localparam logic [3:0]  SC1_IDLE     = 4'h0;

	// Error counter
	localparam int          ERRCNT_W     = 8;
	localparam logic [7:0]  ERRCNT_ZERO  = 8'h00;
	localparam logic [7:0]  ERRCNT_MAX   = 8'hff;
	localparam logic [7:0]  ERRCNT_STEP  = 8'h01;

	// Control port transfer
	localparam int          XFER_BITS    = 8;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [3:0]  BITCNT_ZERO  = 4'h0;
	localparam logic [3:0]  BITCNT_ONE   = 4'h1;
	localparam logic [3:0]  BITCNT_LAST  = 4'h8;

	// Command opcodes in the upper nibble of a received byte
	localparam logic [3:0]  OP_NOP       = 4'h0;
	localparam logic [3:0]  OP_INT_EN    = 4'h1;
	localparam logic [3:0]  OP_INT_DIS   = 4'h2;
	localparam logic [3:0]  OP_LOAD_HIGH = 4'h3;
	localparam logic [3:0]  OP_LOAD_LOW  = 4'h4;
	localparam logic [3:0]  OP_CNT_CLR   = 4'h5;

	typedef enum logic [3:0] {
		SP_IDLE  = 4'b0001,
		SP_WAIT  = 4'b0010,
		SP_SHIFT = 4'b0100,
		SP_END   = 4'b1000
	} mfem_sp_state_t;

	// One received frame, presented with strobe at the frame's end
	typedef struct packed {
		logic strobe;
		logic mfSync;
		logic qFrame;
		logic codeViol;
		logic dcFault;
		logic sc1Slot;
		logic sBit;
	} mfem_frame_t;

	typedef struct packed {
		logic       mfErr;
		logic       sc1Msg;
		logic       intEn;
		logic       highPend;
		logic [3:0] rxCode;
	} mfem_status_t;

	typedef struct packed {
		logic [3:0] opcode;
		logic [3:0] arg;
	} mfem_cmd_t;

endpackage

// ### design/mfem_edge.sv
`timescale 1ns/100ps
`default_nettype none
module mfem_edge
	import mfem_pkg::*;
#(
	parameter logic IDLE_LEVEL = 1'b1
)
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic ce,
	// Sampled level
	input  wire logic din,
	// Edge pulses
	output logic      rise,
	output logic      fall
);

	logic prev_r;

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			prev_r <= IDLE_LEVEL;
		else if (ce)
			prev_r <= din;
	end

	assign rise = ce & din & ~prev_r;
	assign fall = ce & ~din & prev_r;

endmodule
`default_nettype wire

// ### design/mfem_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
module mfem_serial_port
	import mfem_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// Line events
	input  wire logic       csFall,
	input  wire logic       csRise,
	input  wire logic       sckRise,
	input  wire logic       sckFall,
	input  wire logic       sdiIn,
	// Byte side
	input  wire logic [7:0] txByte,
	output logic [7:0]      rxByte,
	output logic            rxValid,
	// Serial output pin
	output logic            sdo,
	output logic            sdoOe
);

	mfem_sp_state_t state_r;
	logic [7:0]     shTx_r;
	logic [3:0]     bitCnt_r;

	// Either idle level: falls before the first rise are ignored
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state_r  <= SP_IDLE;
			shTx_r   <= BYTE_ZERO;
			rxByte   <= BYTE_ZERO;
			bitCnt_r <= BITCNT_ZERO;
			rxValid  <= 1'b0;
			sdo      <= 1'b0;
			sdoOe    <= 1'b0;
		end
		else if (ce)
		begin
			rxValid <= 1'b0;
			if (csRise)
			begin
				state_r <= SP_IDLE;
				sdoOe   <= 1'b0;
			end
			else if (csFall)
			begin
				state_r  <= SP_WAIT;
				shTx_r   <= txByte;
				sdo      <= txByte[XFER_BITS-1];
				sdoOe    <= 1'b1;
				bitCnt_r <= BITCNT_ZERO;
			end
			else
			begin
				unique case (state_r)
					SP_IDLE, SP_END: ;
					SP_WAIT, SP_SHIFT:
					begin
						if (sckRise)
						begin
							rxByte   <= {rxByte[XFER_BITS-2:0], sdiIn}; // [RL14]
							bitCnt_r <= bitCnt_r + BITCNT_ONE;
							state_r  <= SP_SHIFT;
							if (bitCnt_r + BITCNT_ONE == BITCNT_LAST) // [RL12] [RL13]
							begin
								rxValid <= 1'b1;
								state_r <= SP_END;
							end
						end
						else if (sckFall && state_r == SP_SHIFT)
						begin
							shTx_r <= {shTx_r[XFER_BITS-2:0], 1'b0};
							sdo    <= shTx_r[XFER_BITS-2]; // [RL14]
						end
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ### design/mfem_monitor.sv
// Behaviour
// RL1: Flag multiframe holding any line error, both modes
// RL2: Host loads FECV into high SC1 register
// RL3: High message sent once, then low message
// RL4: Network mode: code violations skip Q frames
// RL5: Network mode: DC balance checked all frames
// RL6: Detector always runs, messaging or not
// RL7: Interrupt masked until enable command arrives
// RL8: Terminal mode: single FECV raises message interrupt
// RL9: Terminal mode: violations and balance, all frames
// RL10: Terminal S bits ignore auxiliary framing pulses
// RL11: Terminal host may count multiframe errors
// RL12: Control port: clock idles low format
// RL13: Control port: clock idles high format
// RL14: Output on falling edge, input on rising
`timescale 1ns/100ps
`default_nettype none
module mfem_monitor
	import mfem_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	// Mode: high for network termination, low for terminal
	input  wire logic         ntMode,
	// Received frame events from the framer
	input  wire mfem_frame_t  frameIn,
	// Control port pins
	input  wire logic         csn,
	input  wire logic         serialShiftClock,
	input  wire logic         serialInputPin,
	output logic              serialOutputPin,
	output logic              serialOutputPinOe,
	// SC1 channel
	output logic [3:0]        sc1TxCode_r,
	output logic [3:0]        sc1RxCode_r,
	// Flags and interrupt
	output logic              rxMultiframeError_r,
	output logic              sc1MessageReceivedInterrupt_r,
	output logic              intReq_r,
	output logic [7:0]        mfErrCount_r
);

	logic [4:0]   frameIdx_r;
	logic [4:0]   curIdx;
	logic         mfEnd;
	logic         cvHit;
	logic         dcHit;
	logic         mfBadAcc_r;
	logic         mfBad;
	logic [3:0]   rxNib_r;
	logic [3:0]   rxNibNxt;
	logic [3:0]   sc1TxHigh_r;
	logic [3:0]   sc1TxLow_r;
	logic         highPend_r;
	logic         intEn_r;
	logic         snapMfErr_r;
	logic         snapSc1_r;
	logic         csRise;
	logic         csFall;
	logic         sckRise;
	logic         sckFall;
	logic [7:0]   rxByte;
	logic         rxValid;
	mfem_cmd_t    cmd;
	mfem_status_t status;
	logic         cmdLoadHigh;
	logic         cmdLoadLow;
	logic         cmdIntEn;
	logic         cmdIntDis;
	logic         cmdCntClr;
	logic         readDone;

	// Frame position within the multiframe
	always_comb
	begin
		curIdx = frameIdx_r;
		if (frameIn.mfSync)
			curIdx = FRAME_FIRST;
	end

	assign mfEnd = ce & frameIn.strobe & (curIdx == FRAME_LAST);

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			frameIdx_r <= FRAME_FIRST;
		else if (ce && frameIn.strobe)
		begin
			if (curIdx == FRAME_LAST)
				frameIdx_r <= FRAME_FIRST;
			else
				frameIdx_r <= curIdx + FRAME_STEP;
		end
	end

	// Error qualification; never gated by message use [RL6]
	always_comb
	begin
		cvHit = ce & frameIn.strobe & frameIn.codeViol;
		if (ntMode && frameIn.qFrame)
			cvHit = 1'b0; // [RL4]
		// Terminal mode keeps every frame [RL9]
		dcHit = ce & frameIn.strobe & frameIn.dcFault; // [RL5] [RL9]
	end

	assign mfBad = mfBadAcc_r | cvHit | dcHit;

	// A resync drops the partial multiframe gathered so far
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			mfBadAcc_r <= 1'b0;
		else if (ce)
		begin
			if (mfEnd)
				mfBadAcc_r <= 1'b0;
			else if (frameIn.strobe && frameIn.mfSync)
				mfBadAcc_r <= cvHit | dcHit;
			else if (cvHit || dcHit)
				mfBadAcc_r <= 1'b1;
		end
	end

	// Received S bits: framer slot only, no auxiliary pulse [RL10]
	always_comb
	begin
		rxNibNxt = rxNib_r;
		if (frameIn.strobe && frameIn.sc1Slot && !ntMode)
			rxNibNxt = {rxNib_r[2:0], frameIn.sBit};
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			rxNib_r     <= SC1_IDLE;
			sc1RxCode_r <= SC1_IDLE;
		end
		else if (ce)
		begin
			rxNib_r <= rxNibNxt;
			if (mfEnd && !ntMode)
				sc1RxCode_r <= rxNibNxt;
		end
	end

	// Command decode from the control port
	assign cmd = mfem_cmd_t'(rxByte);

	always_comb
	begin
		cmdLoadHigh = 1'b0;
		cmdLoadLow  = 1'b0;
		cmdIntEn    = 1'b0;
		cmdIntDis   = 1'b0;
		cmdCntClr   = 1'b0;
		if (rxValid)
		begin
			unique case (cmd.opcode)
				OP_NOP:       ;
				OP_INT_EN:    cmdIntEn    = 1'b1;
				OP_INT_DIS:   cmdIntDis   = 1'b1;
				OP_LOAD_HIGH: cmdLoadHigh = 1'b1;
				OP_LOAD_LOW:  cmdLoadLow  = 1'b1;
				OP_CNT_CLR:   cmdCntClr   = 1'b1;
				default:      ;
			endcase
		end
	end

	assign readDone = rxValid;

	// SC1 transmit: high message goes out once per load [RL2] [RL3]
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			sc1TxHigh_r <= SC1_FECV;
			sc1TxLow_r  <= SC1_IDLE;
			highPend_r  <= 1'b0;
			sc1TxCode_r <= SC1_IDLE;
		end
		else if (ce)
		begin
			if (mfEnd)
			begin
				if (highPend_r)
					sc1TxCode_r <= sc1TxHigh_r; // [RL3]
				else
					sc1TxCode_r <= sc1TxLow_r; // [RL3]
			end
			if (cmdLoadHigh)
			begin
				sc1TxHigh_r <= cmd.arg;
				highPend_r  <= 1'b1;
			end
			else if (mfEnd)
				highPend_r  <= 1'b0; // [RL3]
			if (cmdLoadLow)
				sc1TxLow_r  <= cmd.arg;
		end
	end

	// Enable stays low from reset until the enable command [RL7]
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			intEn_r <= 1'b0;
		else if (ce)
		begin
			if (cmdIntEn)
				intEn_r <= 1'b1; // [RL7]
			else if (cmdIntDis)
				intEn_r <= 1'b0;
		end
	end

	// Flags: a status read clears what it saw; a new set wins
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			rxMultiframeError_r           <= 1'b0;
			sc1MessageReceivedInterrupt_r <= 1'b0;
		end
		else if (ce)
		begin
			if (mfEnd && mfBad)
				rxMultiframeError_r <= 1'b1; // [RL1]
			else if (readDone && snapMfErr_r)
				rxMultiframeError_r <= 1'b0;
			if (mfEnd && !ntMode && rxNibNxt == SC1_FECV)
				sc1MessageReceivedInterrupt_r <= 1'b1; // [RL8]
			else if (readDone && snapSc1_r)
				sc1MessageReceivedInterrupt_r <= 1'b0;
		end
	end

	// Count of bad multiframes for the host, saturating [RL11]
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			mfErrCount_r <= ERRCNT_ZERO;
		else if (ce)
		begin
			if (mfEnd && mfBad && mfErrCount_r != ERRCNT_MAX)
				mfErrCount_r <= mfErrCount_r + ERRCNT_STEP;
			else if (cmdCntClr)
				mfErrCount_r <= ERRCNT_ZERO;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			intReq_r <= 1'b0;
		else if (ce)
			intReq_r <= intEn_r & (rxMultiframeError_r | // [RL1] [RL7]
				sc1MessageReceivedInterrupt_r);
	end

	// Status snapshot taken as chip select falls
	always_comb
	begin
		status.mfErr    = rxMultiframeError_r;
		status.sc1Msg   = sc1MessageReceivedInterrupt_r;
		status.intEn    = intEn_r;
		status.highPend = highPend_r;
		status.rxCode   = sc1RxCode_r;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			snapMfErr_r <= 1'b0;
			snapSc1_r   <= 1'b0;
		end
		else if (ce && csFall)
		begin
			snapMfErr_r <= rxMultiframeError_r;
			snapSc1_r   <= sc1MessageReceivedInterrupt_r;
		end
	end

	mfem_edge #(
		.IDLE_LEVEL (1'b1)
	) u_csEdge (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.din     (csn),
		.rise    (csRise),
		.fall    (csFall)
	);

	// Idle level of the shift clock is taken as low at reset
	mfem_edge #(
		.IDLE_LEVEL (1'b0)
	) u_sckEdge (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.din     (serialShiftClock),
		.rise    (sckRise),
		.fall    (sckFall)
	);

	mfem_serial_port u_port (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.csFall  (csFall),
		.csRise  (csRise),
		.sckRise (sckRise),
		.sckFall (sckFall),
		.sdiIn   (serialInputPin),
		.txByte  (status),
		.rxByte  (rxByte),
		.rxValid (rxValid),
		.sdo     (serialOutputPin),
		.sdoOe   (serialOutputPinOe)
	);

endmodule
`default_nettype wire

// ### verif/mfem_chk_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mfem_chk
	import mfem_pkg::*;
(
	// Clock and controls
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic        ntMode,
	input wire mfem_frame_t frameIn,
	// Control port
	input wire logic        csn,
	input wire logic        serialShiftClock,
	input wire logic        serialOutputPin,
	input wire logic        serialOutputPinOe,
	// Results
	input wire logic [3:0]  sc1TxCode_r,
	input wire logic [3:0]  sc1RxCode_r,
	input wire logic        rxMultiframeError_r,
	input wire logic        sc1MessageReceivedInterrupt_r,
	input wire logic        intReq_r,
	input wire logic [7:0]  mfErrCount_r
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	a_int_lag:
		assert property (intReq_r |->
		$past(rxMultiframeError_r || sc1MessageReceivedInterrupt_r))
		else $error("interrupt without flag");
	a_err_cause:
		assert property ($rose(rxMultiframeError_r) |->
		$past(ce && frameIn.strobe)) else $error("flag without frame");
	a_cnt_flag:
		assert property ($changed(mfErrCount_r) && mfErrCount_r != 8'h00
		|-> rxMultiframeError_r && mfErrCount_r == $past(mfErrCount_r)
		+ 8'h01) else $error("bad count step");
	a_tx_timing:
		assert property ($changed(sc1TxCode_r) |->
		$past(ce && frameIn.strobe)) else $error("tx code off frame");
	a_rx_timing:
		assert property ($changed(sc1RxCode_r) |->
		$past(frameIn.strobe && !ntMode)) else $error("rx code off frame");
	a_msg_fecv:
		assert property ($rose(sc1MessageReceivedInterrupt_r) |->
		!$past(ntMode) && sc1RxCode_r == SC1_FECV)
		else $error("bad message flag");
	a_oe_select:
		assert property ($rose(serialOutputPinOe) |-> $past(!csn))
		else $error("drive without select");
	a_out_fall:
		assert property ($changed(serialOutputPin) && serialOutputPinOe &&
		$past(serialOutputPinOe) |-> !serialShiftClock)
		else $error("output moved on high clock");
	a_flag_clear:
		assert property ($fell(rxMultiframeError_r) |->
		$past(serialOutputPinOe)) else $error("flag lost");
endmodule

bind mfem_monitor mfem_chk mfem_chk_inst (.ref_clk, .rstn, .ce, .ntMode,
	.frameIn, .csn, .serialShiftClock, .serialOutputPin, .serialOutputPinOe,
	.sc1TxCode_r, .sc1RxCode_r, .rxMultiframeError_r,
	.sc1MessageReceivedInterrupt_r, .intReq_r, .mfErrCount_r);
`default_nettype wire

// ### verif/mfem_host.sv
`timescale 1ns/100ps
`default_nettype none
module mfem_host
(
	// Clock
	input  wire logic ref_clk,
	// Control port pins
	output logic      csn,
	output logic      serialShiftClock,
	output logic      serialInputPin,
	input  wire logic serialOutputPin
);
	initial
	begin
		csn = 1'b1;
		serialShiftClock = 1'b0;
		serialInputPin = 1'b0;
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// One byte per select, MSB first, clock levels held 3 cycles
	task automatic xfer(input logic [7:0] cmd, input logic idleHi,
		output logic [7:0] st);
		serialShiftClock = idleHi;
		wait_n(3);
		csn = 1'b0;
		wait_n(4);
		for (int i = 7; i >= 0; i--)
		begin
			serialShiftClock = 1'b0;
			serialInputPin = cmd[i];
			wait_n(3);
			st[i] = serialOutputPin;
			serialShiftClock = 1'b1;
			wait_n(3);
		end
		serialShiftClock = idleHi;
		wait_n(3);
		csn = 1'b1;
		serialInputPin = ~serialInputPin;
		wait_n(3);
	endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
	n_compared++; \
	if ((a) !== (b)) \
	begin \
		n_mismatch++; \
		$display("[FAIL] %0t got %h exp %h", $time, a, b); \
	end
module tb_top
	import mfem_pkg::*;
;
	logic        ref_clk;
	logic        rstn;
	logic        ce;
	logic        ntMode;
	mfem_frame_t frameIn;
	logic        csn;
	logic        sck;
	logic        sdi;
	logic        sdo;
	logic        sdoOe;
	logic [3:0]  txCode;
	logic [3:0]  rxCode;
	logic        mfErr;
	logic        msgInt;
	logic        intReq;
	logic [7:0]  errCnt;
	logic [7:0]  expCnt;
	logic [7:0]  st;
	int          n_mismatch;
	int          n_compared;

	mfem_monitor mfem_monitor_inst (.ref_clk(ref_clk), .rstn(rstn),
		.ce(ce), .ntMode(ntMode), .frameIn(frameIn), .csn(csn),
		.serialShiftClock(sck), .serialInputPin(sdi),
		.serialOutputPin(sdo), .serialOutputPinOe(sdoOe),
		.sc1TxCode_r(txCode), .sc1RxCode_r(rxCode),
		.rxMultiframeError_r(mfErr),
		.sc1MessageReceivedInterrupt_r(msgInt), .intReq_r(intReq),
		.mfErrCount_r(errCnt));

	// Released pin reads as the inverse of the last driven bit
	mfem_host mfem_host_inst (.ref_clk(ref_clk), .csn(csn),
		.serialShiftClock(sck), .serialInputPin(sdi),
		.serialOutputPin(sdoOe ? sdo : ~sdo));

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One multiframe, a frame each cycle; every fifth frame holds Q data
	task automatic mframe(input int cvAt, input int dcAt,
		input logic [3:0] nib);
		mfem_frame_t f;
		logic        e;
		for (int k = 0; k < 20; k++)
		begin
			f = '0;
			f.strobe = 1'b1;
			f.mfSync = (k == 0);
			f.qFrame = (k % 5 == 0);
			f.codeViol = (k == cvAt);
			f.dcFault = (k == dcAt);
			f.sc1Slot = (k >= 16);
			f.sBit = (k >= 16) && nib[19 - k];
			frameIn = f;
			step(1);
		end
		frameIn = '0;
		e = (dcAt >= 0) || (cvAt >= 0 && (!ntMode || cvAt % 5 != 0));
		if (e && ce)
		begin
			expCnt++;
			`CHK(mfErr, 1'b1)
		end
		`CHK(errCnt, expCnt)
	endtask

	initial
	begin
		step(20000);
		n_mismatch++;
		close_out();
	end

	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		expCnt = 8'h00;
		rstn = 1'b0;
		ce = 1'b1;
		ntMode = 1'b1;
		frameIn = '0;
		step(20);
		rstn = 1'b1;
		`CHK({mfErr, msgInt, intReq, errCnt, txCode}, 15'h0)
		`CHK({sdoOe, rxCode}, 5'h00)
		mframe(5, -1, SC1_IDLE);
		mframe(-1, 10, SC1_IDLE);
		mframe(19, -1, SC1_IDLE);
		step(2);
		`CHK(intReq, 1'b0)
		mfem_host_inst.xfer(8'h10, 1'b0, st);
		`CHK(st, 8'h80)
		`CHK(mfErr, 1'b0)
		mframe(-1, 0, SC1_IDLE);
		`CHK(intReq, 1'b0)
		step(1);
		`CHK(intReq, 1'b1)
		mfem_host_inst.xfer(8'h45, 1'b0, st);
		`CHK(st, 8'ha0)
		mfem_host_inst.xfer({OP_LOAD_HIGH, SC1_FECV}, 1'b0, st);
		`CHK(st, 8'h20)
		mframe(-1, -1, SC1_IDLE);
		`CHK(txCode, SC1_FECV)
		mframe(-1, -1, SC1_IDLE);
		`CHK(txCode, 4'h5)
		ce = 1'b0;
		mframe(3, -1, SC1_IDLE);
		ce = 1'b1;
		mfem_host_inst.xfer(8'h50, 1'b1, st);
		`CHK(st, 8'h20)
		`CHK(sdoOe, 1'b0)
		expCnt = 8'h00;
		step(2);
		`CHK(errCnt, expCnt)
		ntMode = 1'b0;
		mframe(0, -1, SC1_FECV);
		`CHK({msgInt, rxCode}, 5'h1e)
		step(1);
		`CHK(intReq, 1'b1)
		mfem_host_inst.xfer(8'h20, 1'b1, st);
		`CHK(st, 8'hee)
		mframe(-1, -1, 4'h7);
		`CHK({msgInt, rxCode}, 5'h07)
		mframe(-1, 19, 4'h7);
		step(2);
		`CHK(intReq, 1'b0)
		mfem_host_inst.xfer(8'h00, 1'b0, st);
		`CHK(st, 8'h87)
		close_out();
	end
endmodule
`default_nettype wire
